//--- src/ssf_pkg.sv
// Constants, types and register map of the SPI port
// What this block does
// - Slave counts edges; eight bits set done flag
// - Done flag raises interrupt request, not gated by enable
// - Byte during set done flag sets overrun
// - Slave never starts; data preloaded by write
// - Late preload sends zero byte next transfer
// - Write into full shifter flags collision only
// - Clock polarity bit sets idle clock level
// - Phase zero: select fall starts each byte
// - Phase one: first clock edge starts byte
// - Master select low: fault, disable, slave
// - Select disable suppresses fault and interrupt
// - Collision flag: no interrupt, software cleared
// - Overrun: done keeps interrupting; no own interrupt
// - Bit order bit picks first shifted bit
// - Master select bit picks master or slave
// - Rate field divides system clock by 4..128
// - Enable bit switches interface off or on
// - Data write loads shifter; read gives received
// - Data read is meaningless while disabled
// - Hardware only sets the four status flags
// - Unselected slave releases output and ignores clock
package ssf_pkg;

  localparam logic [7:0] SSF_ADDR_CTRL = 8'ha2;
  localparam logic [7:0] SSF_ADDR_DATA = 8'ha3;
  localparam logic [7:0] SSF_ADDR_STAT = 8'hf8;

  localparam logic [7:0] SSF_RESET_BYTE = 8'h00;
  localparam logic [7:0] SSF_LATE_BYTE = 8'h00;
  localparam logic [2:0] SSF_LAST_BIT = 3'h7;
  localparam logic [3:0] SSF_LAST_EDGE = 4'hf;
  localparam logic [1:0] SSF_BUF_DEPTH = 2'h2;

  // Half periods of the master clock, in system clocks
  localparam logic [6:0] SSF_HALF_DIV4 = 7'h02;
  localparam logic [6:0] SSF_HALF_DIV8 = 7'h04;
  localparam logic [6:0] SSF_HALF_DIV16 = 7'h08;
  localparam logic [6:0] SSF_HALF_DIV32 = 7'h10;
  localparam logic [6:0] SSF_HALF_DIV64 = 7'h20;
  localparam logic [6:0] SSF_HALF_DIV128 = 7'h40;

  // Field layout follows bit 7 down to bit 0
  typedef struct packed {
    logic lsb_first;
    logic master_select;
    logic clock_phase;
    logic clock_polarity;
    logic select_pin_disable;
    logic [2:0] rate;
  } ssf_ctrl_t;

  typedef struct packed {
    logic spi_enable_bit;
    logic done;
    logic mode_fault_flag;
    logic write_collision_flag;
    logic overrun_flag;
    logic [2:0] rsvd;
  } ssf_stat_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ssf_sfr_req_t;

  typedef enum logic [1:0] {
    SSF_ST_IDLE = 2'b00,
    SSF_ST_RUN = 2'b01,
    SSF_ST_HOLD = 2'b11
  } ssf_state_t;

  function automatic logic [6:0] ssf_half_period(input logic [2:0] rate);
    case (rate)
      3'h0: ssf_half_period = SSF_HALF_DIV4;
      3'h1: ssf_half_period = SSF_HALF_DIV8;
      3'h2: ssf_half_period = SSF_HALF_DIV16;
      3'h3: ssf_half_period = SSF_HALF_DIV32;
      3'h4: ssf_half_period = SSF_HALF_DIV64;
      default: ssf_half_period = SSF_HALF_DIV128;
    endcase
  endfunction

  function automatic logic [7:0] ssf_shift(input logic [7:0] sh,
                                           input logic din,
                                           input logic lsb_first);
    ssf_shift = lsb_first ? {din, sh[7:1]} : {sh[6:0], din};
  endfunction

endpackage

//--- src/ssf_spi_port.sv
// SPI master/slave port with its three special function registers
`timescale 1ns/1ps
`default_nettype none
module ssf_spi_port import ssf_pkg::*; (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire ssf_sfr_req_t i_sfr,
  output var logic [7:0] o_sfr_rdata,
  output var logic o_irq,
  input wire logic i_ss_n,
  input wire logic i_sck,
  output var logic o_sck,
  output var logic o_sck_oe_n,
  input wire logic i_mosi,
  output var logic o_mosi,
  output var logic o_mosi_oe_n,
  input wire logic i_miso,
  output var logic o_miso,
  output var logic o_miso_oe_n
);

  // Pin synchronisers; first stages feed only second stages
  logic ss_q1, ss_q2, sck_q1, sck_q2, mosi_q1, mosi_q2, miso_q1, miso_q2;
  logic ss_prev, sck_prev;

  ssf_ctrl_t ctrl_reg, ctrl_next;
  logic spi_enable_bit_reg, transfer_done_flag_reg, mode_fault_flag_reg, write_collision_flag_reg, overrun_flag_reg;
  logic [7:0] tx_reg, out_sh_reg, in_sh_reg, rx_data_reg;
  logic tx_full_reg;
  logic [2:0] bitcnt_reg;
  logic [3:0] ecnt_reg;
  logic [6:0] div_reg;
  logic sck_reg, dout_reg, irq_reg;
  logic sck_oe_n_reg, mosi_oe_n_reg, miso_oe_n_reg;
  logic [7:0] rdata_reg;
  ssf_state_t state_reg, state_next;

  // Two-entry receive buffer between shifter and data register
  logic [7:0] buf_mem [0:1];
  logic buf_wp, buf_rp;
  logic [1:0] buf_cnt;

  // Register access decode
  wire wr_ctrl = i_sfr.wr & (i_sfr.addr == SSF_ADDR_CTRL);
  wire wr_data = i_sfr.wr & (i_sfr.addr == SSF_ADDR_DATA);
  wire wr_stat = i_sfr.wr & (i_sfr.addr == SSF_ADDR_STAT);
  wire rd_ctrl = i_sfr.rd & (i_sfr.addr == SSF_ADDR_CTRL);
  wire rd_data = i_sfr.rd & (i_sfr.addr == SSF_ADDR_DATA);
  wire rd_stat = i_sfr.rd & (i_sfr.addr == SSF_ADDR_STAT);
  wire ssf_stat_t stat_wr = ssf_stat_t'(i_sfr.wdata);

  // Mode and selection
  wire is_master = spi_enable_bit_reg & ctrl_reg.master_select;
  wire is_slave = spi_enable_bit_reg & ~ctrl_reg.master_select;
  // Select disable only frees the pin in phase one
  wire sel = ~ss_q2 | (ctrl_reg.clock_phase & ctrl_reg.select_pin_disable);
  wire ss_fall = ss_prev & ~ss_q2;
  wire busy = (state_reg != SSF_ST_IDLE);

  // Slave clock edges, ignored while not selected
  wire s_edge = is_slave & sel & (sck_q2 ^ sck_prev);
  wire s_lead = s_edge & (sck_prev == ctrl_reg.clock_polarity);

  // Master clock edges from the rate divider
  wire m_run = is_master & (state_reg == SSF_ST_RUN);
  wire m_tick = m_run & (div_reg == 7'h00);
  wire m_lead = m_tick & ~ecnt_reg[0];
  wire m_last = m_tick & (ecnt_reg == SSF_LAST_EDGE);
  wire [6:0] div_load = 7'(ssf_half_period(ctrl_reg.rate) - 7'h01);

  // Sample and shift edges for both phases
  wire in_run = (state_reg == SSF_ST_RUN);
  wire any_edge = in_run & (s_edge | m_tick);
  wire lead = s_lead | m_lead;
  wire sample_e = any_edge & (lead ^ ctrl_reg.clock_phase);
  wire shift_e = any_edge & ~(lead ^ ctrl_reg.clock_phase) &
                 (bitcnt_reg != 3'h0);
  wire din = is_master ? miso_q2 : mosi_q2;
  wire [7:0] in_sh_next = ssf_shift(in_sh_reg, din, ctrl_reg.lsb_first);
  wire byte_done = sample_e & (bitcnt_reg == SSF_LAST_BIT);

  // Transfer start: slave only on master activity
  wire s_start0 = is_slave & ~ctrl_reg.clock_phase & ss_fall;
  wire s_start1 = is_slave & ctrl_reg.clock_phase & s_lead;
  wire s_start = (state_reg == SSF_ST_IDLE) & (s_start0 | s_start1);
  // Data write only accepted into an empty, idle shifter
  wire wr_ok = wr_data & ~busy & ~tx_full_reg;
  wire m_start = is_master & wr_ok;
  wire start = s_start | m_start;
  wire [7:0] load_byte = is_master ? i_sfr.wdata :
                         (tx_full_reg ? tx_reg : SSF_LATE_BYTE);

  // Receive buffer handshakes
  wire buf_in_ready = (buf_cnt != SSF_BUF_DEPTH);
  wire buf_out_valid = (buf_cnt != 2'h0);
  wire buf_out_ready = ~transfer_done_flag_reg;
  wire overrun = byte_done & (transfer_done_flag_reg | ~buf_in_ready);
  wire buf_in_valid = byte_done & ~overrun;
  wire push = buf_in_valid & buf_in_ready;
  wire pop = buf_out_valid & buf_out_ready;

  // Error events
  wire write_collision_flag_evt = wr_data & ~wr_ok;
  wire mode_fault_flag_evt = is_master & ~ctrl_reg.select_pin_disable & ~ss_q2;

  assign ctrl_next = wr_ctrl ? ssf_ctrl_t'(i_sfr.wdata) : ctrl_reg;

  wire ssf_stat_t stat_rd = '{spi_enable_bit: spi_enable_bit_reg, done: transfer_done_flag_reg,
                              mode_fault_flag: mode_fault_flag_reg, write_collision_flag: write_collision_flag_reg,
                              overrun_flag: overrun_flag_reg, rsvd: 3'h0};
  // Data read is not gated by enable; software must not trust it
  wire [7:0] rd_mux = rd_ctrl ? ctrl_reg :
                      rd_data ? rx_data_reg :
                      rd_stat ? stat_rd : SSF_RESET_BYTE;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SSF_ST_IDLE: begin
        if (start) begin
          state_next = SSF_ST_RUN;
        end
      end
      SSF_ST_RUN: begin
        if (m_last) begin
          state_next = SSF_ST_IDLE;
        end else if (is_slave & byte_done) begin
          // Phase zero needs select to rise before the next byte
          state_next = ctrl_reg.clock_phase ? SSF_ST_IDLE : SSF_ST_HOLD;
        end
      end
      SSF_ST_HOLD: begin
        state_next = SSF_ST_HOLD;
      end
      default: begin
        state_next = SSF_ST_IDLE;
      end
    endcase
    if (!spi_enable_bit_reg || (is_slave && !sel)) begin
      state_next = SSF_ST_IDLE;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ss_q1 <= 1'b1;
      ss_q2 <= 1'b1;
      ss_prev <= 1'b1;
      sck_q1 <= 1'b0;
      sck_q2 <= 1'b0;
      sck_prev <= 1'b0;
      mosi_q1 <= 1'b0;
      mosi_q2 <= 1'b0;
      miso_q1 <= 1'b0;
      miso_q2 <= 1'b0;
    end else begin
      ss_q1 <= i_ss_n;
      ss_q2 <= ss_q1;
      ss_prev <= ss_q2;
      sck_q1 <= i_sck;
      sck_q2 <= sck_q1;
      sck_prev <= sck_q2;
      mosi_q1 <= i_mosi;
      mosi_q2 <= mosi_q1;
      miso_q1 <= i_miso;
      miso_q2 <= miso_q1;
    end
  end

  // Control and status; hardware set beats software clear
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_reg <= '0;
      spi_enable_bit_reg <= 1'b0;
      transfer_done_flag_reg <= 1'b0;
      mode_fault_flag_reg <= 1'b0;
      write_collision_flag_reg <= 1'b0;
      overrun_flag_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      if (mode_fault_flag_evt) begin
        ctrl_reg.master_select <= 1'b0;
      end
      spi_enable_bit_reg <= (wr_stat ? stat_wr.spi_enable_bit : spi_enable_bit_reg) & ~mode_fault_flag_evt;
      transfer_done_flag_reg <= pop | (transfer_done_flag_reg & ~(wr_stat & ~stat_wr.done));
      mode_fault_flag_reg <= mode_fault_flag_evt | (mode_fault_flag_reg & ~(wr_stat & ~stat_wr.mode_fault_flag));
      write_collision_flag_reg <= write_collision_flag_evt | (write_collision_flag_reg & ~(wr_stat & ~stat_wr.write_collision_flag));
      overrun_flag_reg <= overrun | (overrun_flag_reg & ~(wr_stat & ~stat_wr.overrun_flag));
    end
  end

  // Shift engine
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= SSF_ST_IDLE;
      tx_reg <= SSF_RESET_BYTE;
      tx_full_reg <= 1'b0;
      out_sh_reg <= SSF_RESET_BYTE;
      in_sh_reg <= SSF_RESET_BYTE;
      bitcnt_reg <= 3'h0;
      ecnt_reg <= 4'h0;
      div_reg <= 7'h00;
    end else begin
      state_reg <= state_next;
      if (wr_ok & ~is_master) begin
        tx_reg <= i_sfr.wdata;
        tx_full_reg <= 1'b1;
      end else if (s_start) begin
        tx_full_reg <= 1'b0;
      end
      if (start) begin
        out_sh_reg <= load_byte;
        bitcnt_reg <= 3'h0;
        ecnt_reg <= 4'h0;
      end else begin
        if (shift_e) begin
          out_sh_reg <= ssf_shift(out_sh_reg, 1'b0, ctrl_reg.lsb_first);
        end
        if (sample_e) begin
          in_sh_reg <= in_sh_next;
          bitcnt_reg <= bitcnt_reg + 3'h1;
        end
        if (m_tick) begin
          ecnt_reg <= ecnt_reg + 4'h1;
        end
      end
      div_reg <= (!m_run || m_tick) ? div_load : div_reg - 7'h01;
    end
  end

  // Receive buffer and visible data register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      buf_mem[0] <= SSF_RESET_BYTE;
      buf_mem[1] <= SSF_RESET_BYTE;
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      buf_cnt <= 2'h0;
      rx_data_reg <= SSF_RESET_BYTE;
    end else begin
      if (push) begin
        buf_mem[buf_wp] <= in_sh_next;
        buf_wp <= ~buf_wp;
      end
      if (pop) begin
        // Kept while done flag stands, so overrun keeps old byte
        rx_data_reg <= buf_mem[buf_rp];
        buf_rp <= ~buf_rp;
      end
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  // Pin and bus outputs, all registered
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sck_reg <= 1'b0;
      dout_reg <= 1'b0;
      sck_oe_n_reg <= 1'b1;
      mosi_oe_n_reg <= 1'b1;
      miso_oe_n_reg <= 1'b1;
      irq_reg <= 1'b0;
      rdata_reg <= SSF_RESET_BYTE;
    end else begin
      sck_reg <= !m_run ? ctrl_reg.clock_polarity : (sck_reg ^ m_tick);
      dout_reg <= ctrl_reg.lsb_first ? out_sh_reg[0] : out_sh_reg[7];
      sck_oe_n_reg <= ~is_master;
      mosi_oe_n_reg <= ~is_master;
      miso_oe_n_reg <= ~(is_slave & sel);
      // Collision and overrun never reach the request line
      irq_reg <= transfer_done_flag_reg | (mode_fault_flag_reg & ~ctrl_reg.select_pin_disable);
      rdata_reg <= rd_mux;
    end
  end

  assign o_sck = sck_reg;
  assign o_sck_oe_n = sck_oe_n_reg;
  assign o_mosi = dout_reg;
  assign o_mosi_oe_n = mosi_oe_n_reg;
  assign o_miso = dout_reg;
  assign o_miso_oe_n = miso_oe_n_reg;
  assign o_irq = irq_reg;
  assign o_sfr_rdata = rdata_reg;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  a_done_sets_flag: assert property (
    buf_in_valid && !wr_stat |-> ##[1:3] transfer_done_flag_reg)
    else $error("done flag not set after full byte");

  a_irq_follows_flag: assert property (
    transfer_done_flag_reg && $past(transfer_done_flag_reg) |-> o_irq)
    else $error("done flag without interrupt request");

  a_overrun_keeps: assert property (
    byte_done && transfer_done_flag_reg |=> overrun_flag_reg && $stable(rx_data_reg))
    else $error("overrun lost flag or data");

  a_slave_no_start: assert property (
    is_slave && state_reg == SSF_ST_IDLE && !s_start
    |=> state_reg != SSF_ST_RUN)
    else $error("slave started a transfer by itself");

  a_late_zero_byte: assert property (
    s_start && !tx_full_reg |=> out_sh_reg == SSF_LATE_BYTE)
    else $error("late preload did not send zero");

  a_collision_keeps: assert property (
    wr_data && (busy || tx_full_reg)
    |=> write_collision_flag_reg && tx_reg == $past(tx_reg))
    else $error("collision write changed data or missed flag");

  a_idle_clock_level: assert property (
    !m_run [*2] |-> o_sck == $past(ctrl_reg.clock_polarity))
    else $error("idle clock not at polarity level");

  a_fault_disables: assert property (
    mode_fault_flag_evt |=> mode_fault_flag_reg && !spi_enable_bit_reg && !ctrl_reg.master_select)
    else $error("mode fault did not disable master");

  a_fault_masked: assert property (
    ctrl_reg.select_pin_disable && !mode_fault_flag_reg |=> !mode_fault_flag_reg)
    else $error("fault flagged with select disabled");

  a_miso_released: assert property (
    is_slave && ss_q2 && !ctrl_reg.clock_phase |=> o_miso_oe_n)
    else $error("unselected slave drives output");

endmodule // ssf_spi_port
`default_nettype wire

//--- verification/spi_slave_formats_errors_bench.sv
// Self-checking bench for the SPI port in slave and master roles
`timescale 1ns/1ps
`default_nettype none
module spi_slave_formats_errors_bench import ssf_pkg::*; ();
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] to_master;
    logic [7:0] to_slave;
  } ssf_row_t;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  ssf_sfr_req_t sfr = '0;
  logic [7:0] rdata;
  logic [7:0] got;
  logic irq, sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
  logic ss_n, sck, mosi, miso_line;
  int n;
  int fails = 0;
  int samples_checked = 0;
  ssf_row_t rows [8] = '{
    '{8'h00, 8'hA5, 8'h3C}, '{8'h10, 8'h1E, 8'hC8},
    '{8'h90, 8'h81, 8'h7E}, '{8'h80, 8'h06, 8'hD2},
    '{8'h20, 8'h4B, 8'h90}, '{8'hA0, 8'hE1, 8'h35},
    '{8'h30, 8'h59, 8'h0F}, '{8'hB0, 8'hC6, 8'h6A}};

  always #5 clk = ~clk;
  // Released line shows the inverse, not a stale level
  assign miso_line = miso_oe_n ? ~miso_o : miso_o;

  ssf_spi_port uut (.i_clk(clk), .i_resetn(rst_n), .i_sfr(sfr),
    .o_sfr_rdata(rdata), .o_irq(irq), .i_ss_n(ss_n), .i_sck(sck),
    .o_sck(sck_o), .o_sck_oe_n(sck_oe_n), .i_mosi(mosi),
    .o_mosi(mosi_o), .o_mosi_oe_n(mosi_oe_n), .i_miso(miso_line),
    .o_miso(miso_o), .o_miso_oe_n(miso_oe_n));

  ssf_spi_master_model mdl (.i_clk(clk), .i_miso(miso_line),
    .o_ss_n(ss_n), .o_sck(sck), .o_mosi(mosi));

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    sfr <= '0;
  endtask

  task automatic rchk(input string what, input logic [7:0] a,
                      input logic [7:0] exp);
    @(posedge clk);
    sfr <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    sfr <= '0;
    #1 chk(what, exp, rdata);
  endtask

  task automatic gap(output int cnt);
    logic s;
    s = sck_o;
    cnt = 0;
    @(posedge clk);
    while (sck_o === s && cnt < 200) begin
      cnt++;
      @(posedge clk);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    wr(SSF_ADDR_STAT, 8'h80);
    for (int k = 0; k < 8; k++) begin
      wr(SSF_ADDR_CTRL, rows[k].ctrl);
      wr(SSF_ADDR_DATA, rows[k].to_master);
      mdl.xfer(rows[k].ctrl, rows[k].to_slave, got);
      repeat (6) @(posedge clk);
      chk("master rx", rows[k].to_master, got);
      chk("irq", 8'h01, {7'h00, irq});
      chk("sck idle", {7'h00, rows[k].ctrl[4]}, {7'h00, sck_o});
      rchk("status", SSF_ADDR_STAT, 8'hC0);
      rchk("data", SSF_ADDR_DATA, rows[k].to_slave);
      wr(SSF_ADDR_STAT, 8'h80);
    end
    mdl.sel(1'b1);
    chk("miso release", 8'h01, {7'h00, miso_oe_n});
    // Overrun: second byte lands while the done flag is still up
    wr(SSF_ADDR_CTRL, 8'h00);
    wr(SSF_ADDR_DATA, 8'h11);
    mdl.xfer(8'h00, 8'h3C, got);
    // Select rise needs the sync delay before the shifter is free again
    repeat (6) @(posedge clk);
    wr(SSF_ADDR_DATA, 8'h22);
    mdl.xfer(8'h00, 8'hC3, got);
    repeat (6) @(posedge clk);
    chk("master rx", 8'h22, got);
    rchk("status", SSF_ADDR_STAT, 8'hC8);
    rchk("data", SSF_ADDR_DATA, 8'h3C);
    chk("irq", 8'h01, {7'h00, irq});
    wr(SSF_ADDR_STAT, 8'hF8);
    rchk("status", SSF_ADDR_STAT, 8'hC8);
    wr(SSF_ADDR_STAT, 8'h80);
    // Request line is registered one cycle behind the flag
    repeat (2) @(posedge clk);
    chk("irq", 8'h00, {7'h00, irq});
    // No preload, then a write in mid-byte
    fork
      mdl.xfer(8'h00, 8'h5A, got);
      begin
        repeat (40) @(posedge clk);
        wr(SSF_ADDR_DATA, 8'h77);
      end
    join
    repeat (6) @(posedge clk);
    chk("late byte", 8'h00, got);
    rchk("status", SSF_ADDR_STAT, 8'hD0);
    rchk("data", SSF_ADDR_DATA, 8'h5A);
    wr(SSF_ADDR_STAT, 8'h90);
    rchk("status", SSF_ADDR_STAT, 8'h90);
    chk("irq", 8'h00, {7'h00, irq});
    // Mode fault, then the same with the select pin disabled
    wr(SSF_ADDR_STAT, 8'h80);
    wr(SSF_ADDR_CTRL, 8'h40);
    mdl.sel(1'b0);
    chk("irq", 8'h01, {7'h00, irq});
    rchk("status", SSF_ADDR_STAT, 8'h20);
    rchk("control", SSF_ADDR_CTRL, 8'h00);
    mdl.sel(1'b1);
    wr(SSF_ADDR_STAT, 8'h00);
    wr(SSF_ADDR_CTRL, 8'h48);
    wr(SSF_ADDR_STAT, 8'h80);
    mdl.sel(1'b0);
    chk("irq", 8'h00, {7'h00, irq});
    rchk("status", SSF_ADDR_STAT, 8'h80);
    mdl.sel(1'b1);
    for (int r = 0; r < 8; r++) begin
      wr(SSF_ADDR_CTRL, 8'h40 | 8'(r));
      wr(SSF_ADDR_DATA, 8'hA5);
      gap(n);
      gap(n);
      chk("half period", 8'(2 << (r > 5 ? 5 : r)), 8'(n + 1));
      repeat (1100) @(posedge clk);
      wr(SSF_ADDR_STAT, 8'h80);
    end
    // Reset after the last transfer brings every register back to zero
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rchk("control", SSF_ADDR_CTRL, 8'h00);
    rchk("status", SSF_ADDR_STAT, 8'h00);
    rchk("data", SSF_ADDR_DATA, 8'h00);
    wr(8'h55, 8'hFF);
    rchk("unmapped", 8'h55, 8'h00);
    mdl.xfer(8'h00, 8'h99, got);
    repeat (6) @(posedge clk);
    rchk("status", SSF_ADDR_STAT, 8'h00);
    chk("miso off", 8'h01, {7'h00, miso_oe_n});
    give_verdict();
  end
endmodule // spi_slave_formats_errors_bench
`default_nettype wire

//--- verification/ssf_spi_master_model.sv
// Behavioural SPI master that drives the port while it is a slave
`timescale 1ns/1ps
`default_nettype none
module ssf_spi_master_model import ssf_pkg::*; (
  input wire logic i_clk,
  input wire logic i_miso,
  output var logic o_ss_n,
  output var logic o_sck,
  output var logic o_mosi
);
  // Eight system clocks a half period, well above the edge spacing
  localparam int HALF = 8;

  initial begin
    o_ss_n = 1'b1;
    o_sck = 1'b0;
    o_mosi = 1'b0;
  end

  task automatic hold();
    repeat (HALF) @(posedge i_clk);
  endtask

  task automatic sel(input logic v);
    @(posedge i_clk);
    o_ss_n <= v;
    hold();
  endtask

  // Same phase, polarity and order as the slave
  task automatic xfer(input ssf_ctrl_t c, input logic [7:0] tx,
                      output logic [7:0] rx);
    rx = 8'h00;
    @(posedge i_clk);
    if (o_ss_n || o_sck !== c.clock_polarity) begin
      o_ss_n <= 1'b1;
      o_sck <= c.clock_polarity;
      hold();
      o_ss_n <= 1'b0;
      o_mosi <= c.lsb_first ? tx[0] : tx[7];
      hold();
    end
    for (int i = 0; i < 8; i++) begin
      o_sck <= ~c.clock_polarity;
      if (c.clock_phase) begin
        o_mosi <= c.lsb_first ? tx[i] : tx[7-i];
      end else begin
        rx = c.lsb_first ? {i_miso, rx[7:1]} : {rx[6:0], i_miso};
      end
      hold();
      o_sck <= c.clock_polarity;
      if (c.clock_phase) begin
        rx = c.lsb_first ? {i_miso, rx[7:1]} : {rx[6:0], i_miso};
      end else if (i < 7) begin
        o_mosi <= c.lsb_first ? tx[i+1] : tx[6-i];
      end
      hold();
    end
    if (!c.clock_phase) begin
      o_ss_n <= 1'b1;
    end
    // Released data line must not look like the last bit
    o_mosi <= ~o_mosi;
  endtask
endmodule // ssf_spi_master_model
`default_nettype wire
